// file: hw/status_regs_consts.svh
// command codes, page codes, bit positions and reset values of the status bank
`ifndef STATUS_REGS_CONSTS_SVH
`define STATUS_REGS_CONSTS_SVH

`define CMD_TEMPERATURE_STATUS 8'h7d
`define CMD_COMM_LOGIC_MEMORY_STATUS 8'h7e

`define PAGE_CHANNEL_A 8'h00
`define PAGE_CHANNEL_B 8'h01
`define PAGE_ALL 8'hff

`define TEMP_OVER_FAULT_BIT 7
`define TEMP_OVER_WARNING_BIT 6
`define TEMP_UNDER_WARNING_BIT 5
`define TEMP_UNDER_FAULT_BIT 4

`define CML_BAD_COMMAND_BIT 7
`define CML_BAD_DATA_BIT 6
`define CML_PEC_FAIL_BIT 5
`define CML_MEMORY_FAULT_BIT 4
`define CML_COMM_FAIL_BIT 1

`define FLAG_RESET_VALUE 1'b0
`define STATUS_ZERO_BYTE 8'h00

`endif

// file: hw/status_regs_pkg.sv
// types shared by the status bank, its checker, host model and bench
package status_regs_pkg;

  // one register access handed over by the command decoder
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [7:0] data;
    logic [7:0] page;
  } reg_access_t;

  // temperature events of one channel, one-cycle pulses
  typedef struct packed {
    logic over_temp_fault;
    logic over_temp_warning;
  } temp_events_t;

  // communication, logic and memory events, one-cycle pulses
  typedef struct packed {
    logic bad_command;
    logic bad_data;
    logic pec_fail;
    logic memory_fault;
    logic comm_fail;
  } cml_events_t;

  // read answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } read_answer_t;

endpackage

// file: hw/sticky_flag.sv
// one latched status flag: hardware sets it, a write of one clears it
`timescale 1ns/10ps
`include "status_regs_consts.svh"

module sticky_flag (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);

  logic flag_q;
  logic flag_d;

  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    flag_d = set_in | (flag_q & ~clear_in);
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flag_q <= `FLAG_RESET_VALUE;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_out = flag_q;

endmodule

// file: hw/pmbus_temp_cml_status.sv
// temperature status registers of the two channels and the shared communication/logic/memory status register
`timescale 1ns/10ps
`include "status_regs_consts.svh"
//
// Behaviour
// - over-temperature fault latches bit 7 of temperature status; reads 0 until it happens.
// - over-temperature warning latches bit 6 of temperature status; reads 0 until it happens.
// - temperature status bits 5 to 0 always read zero.
// - host writing 1 to a supported latched bit clears that flag.
// - the shared status command answers with one summary byte.
// - shared status register is one register, unaffected by the page selection.
// - a bad_command event pulse latches bit 7 of the shared status byte; accesses with other codes are ignored.
// - temperature status per channel; page 00 is A, 01 is B, FF reads A.

module pmbus_temp_cml_status (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input status_regs_pkg::reg_access_t access_in,
  input status_regs_pkg::temp_events_t temp_events_a_in,
  input status_regs_pkg::temp_events_t temp_events_b_in,
  input status_regs_pkg::cml_events_t cml_events_in,
  output status_regs_pkg::read_answer_t answer_out,
  output logic [1:0] temp_flags_a_out,
  output logic [1:0] temp_flags_b_out,
  output logic [4:0] cml_flags_out
);

  import status_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  logic hit_temp;
  logic hit_cml;
  logic sel_a;
  logic sel_b;
  logic wr_temp_a;
  logic wr_temp_b;
  logic wr_cml;

  // page FF writes reach both channels, reads of FF show channel A
  always_comb begin
    hit_temp = 1'b0;
    hit_cml = 1'b0;
    if (access_in.valid && access_in.code == `CMD_TEMPERATURE_STATUS) begin
      hit_temp = 1'b1;
    end else if (access_in.valid && access_in.code == `CMD_COMM_LOGIC_MEMORY_STATUS) begin
      hit_cml = 1'b1;
    end
    sel_a = (access_in.page == `PAGE_CHANNEL_A) || (access_in.page == `PAGE_ALL);
    sel_b = (access_in.page == `PAGE_CHANNEL_B) || (access_in.page == `PAGE_ALL);
    wr_temp_a = hit_temp & access_in.write & sel_a;
    wr_temp_b = hit_temp & access_in.write & sel_b;
    wr_cml = hit_cml & access_in.write;
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched flags

  logic [1:0] temp_set_a;
  logic [1:0] temp_set_b;
  logic [1:0] temp_clr_a;
  logic [1:0] temp_clr_b;
  logic [4:0] cml_set;
  logic [4:0] cml_clr;
  logic [1:0] temp_a;
  logic [1:0] temp_b;
  logic [4:0] cml;

  // flag vector order: temperature {fault, warning}; cml {cmd, data, pec, mem, comm}
  always_comb begin
    temp_set_a = {temp_events_a_in.over_temp_fault, temp_events_a_in.over_temp_warning};
    temp_set_b = {temp_events_b_in.over_temp_fault, temp_events_b_in.over_temp_warning};
    temp_clr_a = {2{wr_temp_a}} &
      {access_in.data[`TEMP_OVER_FAULT_BIT], access_in.data[`TEMP_OVER_WARNING_BIT]};
    temp_clr_b = {2{wr_temp_b}} &
      {access_in.data[`TEMP_OVER_FAULT_BIT], access_in.data[`TEMP_OVER_WARNING_BIT]};
    cml_set = {cml_events_in.bad_command, cml_events_in.bad_data, cml_events_in.pec_fail,
               cml_events_in.memory_fault, cml_events_in.comm_fail};
    // bits 3, 2 and 0 have no cell, so writes to them fall away
    cml_clr = {5{wr_cml}} &
      {access_in.data[`CML_BAD_COMMAND_BIT], access_in.data[`CML_BAD_DATA_BIT],
       access_in.data[`CML_PEC_FAIL_BIT], access_in.data[`CML_MEMORY_FAULT_BIT],
       access_in.data[`CML_COMM_FAIL_BIT]};
  end

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_temp
      sticky_flag u_flag_a (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .set_in(temp_set_a[i]),
        .clear_in(temp_clr_a[i]),
        .flag_out(temp_a[i])
      );
      sticky_flag u_flag_b (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .set_in(temp_set_b[i]),
        .clear_in(temp_clr_b[i]),
        .flag_out(temp_b[i])
      );
    end
    for (i = 0; i < 5; i++) begin : g_cml
      sticky_flag u_flag (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .set_in(cml_set[i]),
        .clear_in(cml_clr[i]),
        .flag_out(cml[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read answer

  read_answer_t answer_q;
  read_answer_t answer_d;
  logic [7:0] temp_byte;
  logic [7:0] cml_byte;

  // a read sees the flags as they stood before this cycle's events
  always_comb begin
    temp_byte = `STATUS_ZERO_BYTE;
    if (sel_a) begin
      temp_byte[`TEMP_OVER_FAULT_BIT] = temp_a[1];
      temp_byte[`TEMP_OVER_WARNING_BIT] = temp_a[0];
    end else if (sel_b) begin
      temp_byte[`TEMP_OVER_FAULT_BIT] = temp_b[1];
      temp_byte[`TEMP_OVER_WARNING_BIT] = temp_b[0];
    end
    cml_byte = `STATUS_ZERO_BYTE;
    cml_byte[`CML_BAD_COMMAND_BIT] = cml[4];
    cml_byte[`CML_BAD_DATA_BIT] = cml[3];
    cml_byte[`CML_PEC_FAIL_BIT] = cml[2];
    cml_byte[`CML_MEMORY_FAULT_BIT] = cml[1];
    cml_byte[`CML_COMM_FAIL_BIT] = cml[0];
    answer_d.valid = (hit_temp | hit_cml) & ~access_in.write;
    answer_d.data = `STATUS_ZERO_BYTE;
    if (hit_temp && !access_in.write) begin
      answer_d.data = temp_byte;
    end else if (hit_cml && !access_in.write) begin
      answer_d.data = cml_byte;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      answer_q <= '0;
    end else begin
      answer_q <= answer_d;
    end
  end

  assign answer_out = answer_q;
  assign temp_flags_a_out = temp_a;
  assign temp_flags_b_out = temp_b;
  assign cml_flags_out = cml;

endmodule

// file: verification/status_bank_assertions.sv
// port checker for the status bank
`timescale 1ns/10ps
module status_bank_checker (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input status_regs_pkg::reg_access_t access_in,
  input status_regs_pkg::temp_events_t temp_events_a_in,
  input status_regs_pkg::temp_events_t temp_events_b_in,
  input status_regs_pkg::cml_events_t cml_events_in,
  input status_regs_pkg::read_answer_t answer_out,
  input logic [1:0] temp_flags_a_out,
  input logic [1:0] temp_flags_b_out,
  input logic [4:0] cml_flags_out
);
  import status_regs_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  wire logic rd = access_in.valid && !access_in.write;
  wire logic wt = access_in.valid && access_in.write && access_in.code == 8'h7d;
  fault_set_a: assert property (temp_events_a_in.over_temp_fault |=> temp_flags_a_out[1])
    else $error("fault a not set");
  warn_b_set_a: assert property (temp_events_b_in.over_temp_warning |=> temp_flags_b_out[0])
    else $error("warning b not set");
  fault_hold_a: assert property (!temp_events_a_in.over_temp_fault && !wt |=> $stable(temp_flags_a_out[1]))
    else $error("fault a not held");
  temp_zero_a: assert property (rd && access_in.code == 8'h7d |=> answer_out.valid && answer_out.data[5:0] == 6'h00)
    else $error("temp low bits set");
  fault_clear_a: assert property (wt && access_in.page inside {8'h00, 8'hff} && access_in.data[7] &&
    !temp_events_a_in.over_temp_fault |=> !temp_flags_a_out[1]) else $error("fault a not cleared");
  page_select_a: assert property (rd && access_in.code == 8'h7d && access_in.page == 8'h01
    |=> answer_out.data[7:6] == $past(temp_flags_b_out)) else $error("page b read wrong");
  cml_read_a: assert property (rd && access_in.code == 8'h7e |=> answer_out.valid &&
    {answer_out.data[7:4], answer_out.data[1]} == $past(cml_flags_out) && answer_out.data[3:2] == 2'b00
    && !answer_out.data[0]) else $error("cml byte wrong");
  bad_cmd_a: assert property (cml_events_in.bad_command |=> cml_flags_out[4])
    else $error("bad command not set");
endmodule
bind pmbus_temp_cml_status status_bank_checker chk (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .access_in(access_in), .temp_events_a_in(temp_events_a_in), .temp_events_b_in(temp_events_b_in),
  .cml_events_in(cml_events_in), .answer_out(answer_out), .temp_flags_a_out(temp_flags_a_out),
  .temp_flags_b_out(temp_flags_b_out), .cml_flags_out(cml_flags_out));

// file: verification/status_host_model.sv
// host side model issuing read byte and write byte accesses
`timescale 1ns/10ps
module host_model (
  input wire logic core_clk_in,
  input status_regs_pkg::read_answer_t answer_in,
  output status_regs_pkg::reg_access_t access_out
);
  import status_regs_pkg::*;
  initial access_out = '0;
  // released bus clears valid and write and shows inverted code, data and page so a stale access never looks valid
  task automatic xfer(input logic w, input logic [7:0] c, p, d, output logic [7:0] q);
    @(posedge core_clk_in);
    access_out <= {1'b1, w, c, d, p};
    @(posedge core_clk_in);
    access_out <= {1'b0, ~access_out[23:0]};
    #1 q = answer_in.valid ? answer_in.data : 8'hxx;
  endtask
endmodule

// file: verification/tb_top.sv
// self-checking bench for the status bank
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t mismatch got %h want %h", $time, g, e); end end
module tb_top;
  import status_regs_pkg::*;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [8:0] ev = '0;
  reg_access_t access;
  read_answer_t answer;
  int fail_count = 0;
  int comparisons = 0;
  always #12.5 core_clk_in = ~core_clk_in;
  pmbus_temp_cml_status uut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .access_in(access),
    .temp_events_a_in(ev[8:7]), .temp_events_b_in(ev[6:5]), .cml_events_in(ev[4:0]), .answer_out(answer),
    .temp_flags_a_out(), .temp_flags_b_out(), .cml_flags_out());
  host_model host (.core_clk_in(core_clk_in), .answer_in(answer), .access_out(access));
  ////////////////////////////////////////////////////////////////
  // reads compare x against the answer; writes send x as data
  task automatic op(input logic w, input logic [7:0] c, p, x);
    logic [7:0] q;
    host.xfer(w, c, p, w ? x : 8'h00, q);
    if (!w) `CHK(q, x)
  endtask
  task automatic pulse(input logic [8:0] v);
    @(posedge core_clk_in);
    ev <= v;
    @(posedge core_clk_in);
    ev <= '0;
  endtask
  task finish_test;
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #50us;
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (8) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    op(0, 8'h7d, 8'h00, 8'h00);
    op(0, 8'h7e, 8'h00, 8'h00);
    pulse(9'b10_01_10000);
    op(0, 8'h7d, 8'h00, 8'h80);
    op(0, 8'h7d, 8'h01, 8'h40);
    op(0, 8'h7d, 8'hff, 8'h80);
    op(0, 8'h7e, 8'h01, 8'h80);
    op(1, 8'h7d, 8'h01, 8'hff);
    op(0, 8'h7d, 8'h01, 8'h00);
    op(0, 8'h7d, 8'h00, 8'h80);
    op(1, 8'h7e, 8'h01, 8'h0d);
    op(0, 8'h7e, 8'h00, 8'h80);
    op(1, 8'h7e, 8'h00, 8'h80);
    op(0, 8'h7e, 8'h01, 8'h00);
    pulse(9'b11_11_11111);
    op(0, 8'h7e, 8'h00, 8'hf2);
    op(0, 8'h7d, 8'h01, 8'hc0);
    op(1, 8'h7d, 8'hff, 8'h80);
    op(0, 8'h7d, 8'h00, 8'h40);
    op(0, 8'h7d, 8'h01, 8'h40);
    op(1, 8'h7e, 8'h00, 8'hff);
    op(0, 8'h7e, 8'h00, 8'h00);
    // mid-run reset must drop every latched flag back to its default
    pulse(9'b11_11_11111);
    resetn_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    op(0, 8'h7d, 8'h00, 8'h00);
    op(0, 8'h7d, 8'h01, 8'h00);
    op(0, 8'h7e, 8'h00, 8'h00);
    finish_test;
  end
endmodule
